/* common/adcp_pkg.sv */
// Constants shared by the converter serial port and its helpers.
// Assumes a 12-bit converter core outside that supplies a finished code.

package adcp_pkg;

	// ****************************************************************
	// Word sizes and configuration field positions (first bit = bit 7).
	// ****************************************************************
	localparam int unsigned CFG_BITS   = 8;
	localparam int unsigned RES_BITS   = 12;
	localparam int unsigned SE_POS     = 7;  // single_ended_select
	localparam int unsigned POL_POS    = 6;  // channel parity / polarity
	localparam int unsigned PAIR_HI    = 5;  // pair_index high bit
	localparam int unsigned PAIR_LO    = 4;  // pair_index low bit
	localparam int unsigned UNI_POS    = 3;  // unipolar_select
	localparam int unsigned HIGH_BIT_FIRST_POS   = 2;  // high_bit_first
	localparam int unsigned WL_HI      = 1;  // word_length_code high bit
	localparam int unsigned WL_LO      = 0;  // word_length_code low bit

	// ****************************************************************
	// Output word lengths and the full configuration bit count, in shift-clock cycles.
	// ****************************************************************
	localparam logic [4:0] LEN_8       = 5'h08;
	localparam logic [4:0] LEN_12      = 5'h0C;
	localparam logic [4:0] LEN_16      = 5'h10;
	localparam logic [4:0] LEN_SHDN    = 5'h0A;
	localparam logic [3:0] CFG_FULL    = 4'h8;

	typedef enum logic [1:0] {
		WL_8BIT  = 2'b00,
		WL_SHDN  = 2'b01,
		WL_12BIT = 2'b10,
		WL_16BIT = 2'b11
	} adcp_wl_t;

	// ****************************************************************
	// Coding, reset values and conversion timing.
	// ****************************************************************
	localparam logic [11:0] BIP_FLIP   = 12'h800; // Offset binary to two's complement.
	localparam logic [11:0] RES_RST    = 12'h000;
	localparam logic [7:0]  CFG_RST    = 8'h00;
	localparam int unsigned CONV_ACLK_CYCLES = 52; // Conversion time in conversion-clock cycles.
	localparam logic [6:0]  CONV_CNT_LOAD = 7'(CONV_ACLK_CYCLES);

endpackage

/* tb/adcp_host_model.sv */
// Host side of the four-wire link: select, shift clock and serial input.
// Assumes the bench calls its tasks just after a rising mclk_in edge.

`timescale 1ns/1ps

module adcp_host_model (
	input  wire logic mclk_in,
	input  wire logic serial_out,
	input  wire logic serial_oe_n_out,
	output logic      select_n_out,
	output logic      sclk_out,
	output logic      serial_data_out
);
	// ****************************************************************
	// Link drive.
	// ****************************************************************

	// The link idles deselected with the shift clock parked low.
	initial begin
		select_n_out = 1'b1;
		sclk_out = 1'b0;
		serial_data_out = 1'b0;
	end

	// Waits for the output enable to reach a level; gives up after 40 clocks.
	task automatic wait_oe(input logic lvl, inout bit ok);
		int w;
		w = 0;
		while (serial_oe_n_out !== lvl && w < 40) begin
			@(posedge mclk_in);
			w++;
		end
		if (w >= 40) ok = 1'b0;
	endtask

	// One select cycle of n shift clocks; phases of five clocks beat the port's three.
	task automatic xfer(input logic [7:0] cfg, input int n, output logic [15:0] rx,
		output bit ok);
		rx = 16'h0000;
		ok = 1'b1;
		select_n_out <= 1'b0;
		serial_data_out <= cfg[7];
		@(posedge mclk_in);
		wait_oe(1'b0, ok);
		// The first bit is launched on the edge after the one that shows the
		// enable, so one more edge passes before it is read.
		@(posedge mclk_in);
		for (int i = 0; i < n; i++) begin
			rx = {rx[14:0], serial_out};
			sclk_out <= 1'b1;
			repeat (5) @(posedge mclk_in);
			sclk_out <= 1'b0;
			// Past the eighth bit the input keeps toggling, so a leak shows up.
			serial_data_out <= (i < 7) ? cfg[6 - i] : ~serial_data_out;
			repeat (5) @(posedge mclk_in);
		end
		select_n_out <= 1'b1;
		serial_data_out <= ~serial_data_out;
		@(posedge mclk_in);
		wait_oe(1'b1, ok);
	endtask

	// Shift clocks sent while deselected, which the port must not count.
	task automatic stray(input int n);
		repeat (n) begin
			sclk_out <= 1'b1;
			repeat (3) @(posedge mclk_in);
			sclk_out <= 1'b0;
			repeat (3) @(posedge mclk_in);
		end
	endtask
endmodule

/* tb/adcp_serial_port_tb.sv */
// Self-checking bench for the converter serial port.
// Assumes the host model above and a converter core played by the bench.

`timescale 1ns/1ps

module adcp_serial_port_tb;
	import adcp_pkg::*;

	// ****************************************************************
	// Signals, clocks and instances.
	// ****************************************************************
	logic        mclk_in = 1'b0;
	logic        aclk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        select_n, sclk, sdin, serial_out, serial_oe_n;
	logic [11:0] adc_code = 12'h000;
	logic [2:0]  mux_pos, mux_neg;
	logic        mux_common, unipolar, conv_start, conv_busy, shutdown;
	logic [7:0]  prev_cfg = 8'h0C;
	logic [11:0] prev_code = 12'h000;
	int          n_fail = 0;
	int          n_tests = 0;
	int          n_starts = 0;
	int          lens[4] = '{8, 10, 12, 16};

	// System clock at 40 MHz.
	always #12.5 mclk_in = ~mclk_in;

	// Conversion clock at 15 ns, offset so its edges drift against mclk_in.
	initial begin
		#3.1;
		forever #7.5 aclk_in = ~aclk_in;
	end

	// Counts conversion requests seen by the converter core.
	always @(posedge mclk_in) if (conv_start === 1'b1) n_starts++;

	adcp_serial_port adcp_serial_port_inst (
		.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .aclk_in(aclk_in),
		.select_n_in(select_n), .sclk_in(sclk), .serial_in(sdin),
		.serial_out(serial_out), .serial_oe_n_out(serial_oe_n),
		.adc_code_in(adc_code), .mux_pos_out(mux_pos), .mux_neg_out(mux_neg),
		.mux_common_out(mux_common), .unipolar_out(unipolar),
		.conv_start_out(conv_start), .conv_busy_out(conv_busy), .shutdown_out(shutdown)
	);

	adcp_host_model adcp_host_model_inst (
		.mclk_in(mclk_in), .serial_out(serial_out), .serial_oe_n_out(serial_oe_n),
		.select_n_out(select_n), .sclk_out(sclk), .serial_data_out(sdin)
	);

	// ****************************************************************
	// Checking helpers.
	// ****************************************************************
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Word the host should collect: coding and order of the requesting word, length n.
	function automatic logic [15:0] fmt(input logic [7:0] cfg, input logic [11:0] code,
		input int n);
		logic [11:0] v;
		logic [15:0] w;
		v = cfg[3] ? code : code ^ 12'h800;
		w = 16'h0000;
		for (int i = 0; i < n; i++) begin
			w = {w[14:0], (i < 12) ? (cfg[2] ? v[11 - i] : v[i]) : 1'b0};
		end
		return w;
	endfunction

	// ****************************************************************
	// Scenarios.
	// ****************************************************************

	// One select cycle; the word returned belongs to the previous request.
	task automatic frame(input logic [7:0] cfg, input logic [11:0] code);
		logic [15:0] rx;
		bit          ok;
		int          s0, w;
		s0 = n_starts;
		adc_code <= code;
		adcp_host_model_inst.xfer(cfg, lens[cfg[1:0]], rx, ok);
		if (!ok) begin
			n_fail++;
			complete_run();
		end
		check(rx, fmt(prev_cfg, prev_code, lens[cfg[1:0]]));
		check({13'h0000, mux_pos}, {13'h0000, cfg[5:4], cfg[6]});
		check({13'h0000, mux_neg}, {13'h0000, cfg[5:4], ~cfg[6]});
		check({15'h0000, mux_common}, {15'h0000, cfg[7]});
		check({15'h0000, unipolar}, {15'h0000, cfg[3]});
		if (cfg[1:0] == 2'b01) begin
			check({15'h0000, shutdown}, 16'h0001);
			check(16'(n_starts - s0), 16'h0000);
		end else begin
			check({15'h0000, shutdown}, 16'h0000);
			w = 0;
			while (conv_busy !== 1'b0 && w < 200) begin
				@(posedge mclk_in);
				w++;
			end
			check(16'(w >= 200), 16'h0000);
			if (w >= 200) begin
				complete_run();
			end
			check(16'(n_starts - s0), 16'h0001);
			prev_cfg = cfg;
			prev_code = code;
		end
	endtask

	// Reset state: port deselected and converter idle.
	task automatic after_reset();
		check({15'h0000, serial_oe_n}, 16'h0001);
		check({13'h0000, conv_start, conv_busy, shutdown}, 16'h0000);
	endtask

	// Main sequence: every field value, every word length, and stray clocks.
	initial begin
		repeat (8) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		repeat (12) @(posedge mclk_in);
		after_reset();
		frame(8'h0E, 12'hABC);
		frame(8'h57, 12'h000);
		frame(8'hA8, 12'hF0F);
		adcp_host_model_inst.stray(3);
		frame(8'hF2, 12'hFFF);
		frame(8'h7F, 12'hFFF);
		frame(8'h0D, 12'h555);
		frame(8'h0E, 12'h000);
		complete_run();
	end
endmodule

/* verilog/adcp_serial_port.sv */
// Serial configuration and result port of a 12-bit acquisition converter.
// Assumes an external converter core: it reads the multiplexer outputs and
// presents a straight-binary code on adc_code_in when the conversion ends.

`timescale 1ns/1ps

// Contract
// - Output changes on fall, input sampled on rise.
// - Config in and result out move together.
// - Transfer starts on recognized select falling edge.
// - Previous result shifts out during config.
// - Conversion starts when the exchange ends.
// - Result appears one select cycle later.
// - Config taken on first eight rising edges.
// - Serial input ignored after eighth bit.
// - First four bits set the multiplexer.
// - Differential pairs, polarity swaps inputs.
// - Single-ended channel is twice pair plus parity.
// - Fifth bit picks unipolar or bipolar.
// - Unipolar output is straight binary.
// - Bipolar output is two's complement.
// - Sixth bit requests high or low bit first.
// - Order affects only output word.
// - Last two bits set length or shutdown.
// - Length applies to the present transfer.
// - Select deglitched by two conversion-clock falls.
// - Shift clock ignored while select high.
module adcp_serial_port
(
	input  wire logic        mclk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        aclk_in,
	input  wire logic        select_n_in,
	input  wire logic        sclk_in,
	input  wire logic        serial_in,
	output logic             serial_out,
	output logic             serial_oe_n_out,
	input  wire logic [11:0] adc_code_in,
	output logic [2:0]       mux_pos_out,
	output logic [2:0]       mux_neg_out,
	output logic             mux_common_out,
	output logic             unipolar_out,
	output logic             conv_start_out,
	output logic             conv_busy_out,
	output logic             shutdown_out
);
	import adcp_pkg::*;

	// ****************************************************************
	// Conversion-clock domain: reset, select deglitch, conversion timer.
	// ****************************************************************

	logic       rst_a1_q;
	logic       rst_a_q;
	logic       sel_a1_q;
	logic       sel_a2_q;
	logic       sel_a3_q;
	logic       sel_rec_q;
	logic       st_a1_q;
	logic       st_a2_q;
	logic       st_a3_q;
	logic [6:0] conv_cnt_q;
	logic       done_tgl_q;
	logic       conv_tgl_q; // Start request toggle, launched on mclk_in.

	// Reset is carried into this domain by two falling-edge flops.
	always_ff @(negedge aclk_in) begin
		rst_a1_q <= sys_rst_in;
		rst_a_q  <= rst_a1_q;
	end

	// A select level must survive two consecutive samples before it is
	// taken, so a pulse narrower than one conversion-clock period is lost.
	always_ff @(negedge aclk_in) begin
		if (rst_a_q) begin
			sel_a1_q  <= 1'b1;
			sel_a2_q  <= 1'b1;
			sel_a3_q  <= 1'b1;
			sel_rec_q <= 1'b1;
		end else begin
			sel_a1_q <= select_n_in;
			sel_a2_q <= sel_a1_q;
			sel_a3_q <= sel_a2_q;
			if (sel_a2_q == sel_a3_q) begin
				sel_rec_q <= sel_a3_q;
			end
		end
	end

	// Start requests arrive as a toggle; completion leaves as a toggle.
	always_ff @(negedge aclk_in) begin
		if (rst_a_q) begin
			st_a1_q    <= 1'b0;
			st_a2_q    <= 1'b0;
			st_a3_q    <= 1'b0;
			conv_cnt_q <= 7'h00;
			done_tgl_q <= 1'b0;
		end else begin
			st_a1_q <= conv_tgl_q;
			st_a2_q <= st_a1_q;
			st_a3_q <= st_a2_q;
			if (st_a2_q != st_a3_q) begin
				conv_cnt_q <= CONV_CNT_LOAD;
			end else if (conv_cnt_q != 7'h00) begin
				conv_cnt_q <= conv_cnt_q - 7'h01;
				if (conv_cnt_q == 7'h01) begin
					done_tgl_q <= ~done_tgl_q;
				end
			end
		end
	end

	// ****************************************************************
	// System clock domain: pin synchronisers and edge detection.
	// ****************************************************************

	logic [3:0]  pins_s;
	logic [11:0] code_s;
	logic        sclk_prev_q;
	logic        done_prev_q;
	logic        act_prev_q;
	logic        act;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        frame_start;
	logic        frame_end;
	logic        done_evt;

	adcp_sync #(.WIDTH(4)) u_pin_sync (
		.clk_in   (mclk_in),
		.rst_in   (sys_rst_in),
		.async_in ({~sel_rec_q, sclk_in, serial_in, done_tgl_q}),
		.sync_out (pins_s)
	);

	// The code is held steady by the core once the conversion is done.
	adcp_sync #(.WIDTH(12)) u_code_sync (
		.clk_in   (mclk_in),
		.rst_in   (sys_rst_in),
		.async_in (adc_code_in),
		.sync_out (code_s)
	);

	// Previous samples for edge detection, taken from synchronised levels.
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			sclk_prev_q <= 1'b0;
			done_prev_q <= 1'b0;
			act_prev_q  <= 1'b0;
		end else begin
			sclk_prev_q <= pins_s[2];
			done_prev_q <= pins_s[0];
			act_prev_q  <= pins_s[3];
		end
	end

	// Shift-clock edges count only inside a recognized select.
	assign act         = pins_s[3];
	assign sclk_rise   = act & pins_s[2] & ~sclk_prev_q;
	assign sclk_fall   = act & ~pins_s[2] & sclk_prev_q;
	assign frame_start = act & ~act_prev_q;
	assign frame_end   = ~act & act_prev_q;
	assign done_evt    = pins_s[0] ^ done_prev_q;

	// ****************************************************************
	// Helpers.
	// ****************************************************************

	// Output length in shift-clock cycles for a word length code.
	function automatic logic [4:0] wl_len(input logic [1:0] wl);
		case (wl)
			WL_8BIT:  wl_len = LEN_8;
			WL_SHDN:  wl_len = LEN_SHDN;
			WL_12BIT: wl_len = LEN_12;
			WL_16BIT: wl_len = LEN_16;
			default:  wl_len = LEN_16;
		endcase
	endfunction

	// Result bit for a position; beyond the word or the length gives zero.
	function automatic logic out_bit(input logic [11:0] word, input logic [4:0] idx,
			input logic high_bit_first, input logic [4:0] len);
		logic [3:0] pos;
		pos = high_bit_first ? 4'(5'd11 - idx) : idx[3:0];
		if (idx >= len || idx >= 5'(RES_BITS)) begin
			out_bit = 1'b0;
		end else begin
			out_bit = word[pos];
		end
	endfunction

	// ****************************************************************
	// Configuration receive.
	// ****************************************************************

	logic [3:0] rx_cnt_q;
	logic [7:0] cfg_sh_q;
	logic [4:0] rise_cnt_q;
	logic [4:0] cur_len;

	// Until the length bits have arrived, no limit is applied yet.
	assign cur_len = (rx_cnt_q == CFG_FULL) ? wl_len(cfg_sh_q[WL_HI:WL_LO]) : LEN_16;

	// Config bits shift in on rising edges; after eight, input is ignored.
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			rx_cnt_q   <= 4'h0;
			cfg_sh_q   <= CFG_RST;
			rise_cnt_q <= 5'h00;
		end else if (frame_start) begin
			rx_cnt_q   <= 4'h0;
			rise_cnt_q <= 5'h00;
		end else if (sclk_rise) begin
			if (rx_cnt_q != CFG_FULL) begin
				cfg_sh_q <= {cfg_sh_q[6:0], pins_s[1]};
				rx_cnt_q <= rx_cnt_q + 4'h1;
			end
			if (rise_cnt_q != 5'h1F) begin
				rise_cnt_q <= rise_cnt_q + 5'h01;
			end
		end
	end

	// ****************************************************************
	// Result transmit.
	// ****************************************************************

	logic [11:0] result_q;
	logic        res_high_bit_first_q;
	logic [4:0]  tx_idx_q;
	logic        dout_q;

	// The first bit is out as soon as select is recognized; each falling
	// edge after a rising edge moves to the next bit, keeping both
	// directions in step.
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			tx_idx_q <= 5'h00;
			dout_q   <= 1'b0;
		end else if (frame_start) begin
			tx_idx_q <= 5'h00;
			dout_q   <= out_bit(result_q, 5'h00, res_high_bit_first_q, LEN_16);
		end else if (sclk_fall && rise_cnt_q != 5'h00) begin
			tx_idx_q <= tx_idx_q + 5'h01;
			dout_q   <= out_bit(result_q, tx_idx_q + 5'h01, res_high_bit_first_q, cur_len);
		end
	end

	assign serial_out      = dout_q;
	assign serial_oe_n_out = ~act;

	// ****************************************************************
	// Conversion request, shutdown and result capture.
	// ****************************************************************

	logic       started_q;
	logic       conv_start_q;
	logic       busy_q;
	logic       shdn_q;
	logic [7:0] cfg_q;
	logic       end_now;

	// The exchange ends when the length is reached, or at select release
	// if the host stopped early with a whole configuration in hand.
	assign end_now = ~started_q && rx_cnt_q == CFG_FULL &&
		(rise_cnt_q >= cur_len || frame_end);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			conv_tgl_q   <= 1'b0;
			started_q    <= 1'b0;
			conv_start_q <= 1'b0;
			shdn_q       <= 1'b0;
			cfg_q        <= CFG_RST;
		end else begin
			conv_start_q <= 1'b0;
			if (frame_start) begin
				started_q <= 1'b0;
				shdn_q    <= 1'b0;
			end else if (end_now) begin
				started_q <= 1'b1;
				cfg_q     <= cfg_sh_q;
				if (cfg_sh_q[WL_HI:WL_LO] == WL_SHDN) begin
					shdn_q <= 1'b1;
				end else begin
					conv_tgl_q   <= ~conv_tgl_q;
					conv_start_q <= 1'b1;
				end
			end
		end
	end

	// A finished code is coded for the requested mode and held for the
	// next transfer; the order bit travels with it.
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			busy_q     <= 1'b0;
			result_q   <= RES_RST;
			res_high_bit_first_q <= 1'b1;
		end else if (conv_start_q) begin
			busy_q <= 1'b1;
		end else if (done_evt) begin
			busy_q     <= 1'b0;
			res_high_bit_first_q <= cfg_q[HIGH_BIT_FIRST_POS];
			if (cfg_q[UNI_POS]) begin
				result_q <= code_s;
			end else begin
				result_q <= code_s ^ BIP_FLIP;
			end
		end
	end

	// Positive input is the same formula in both modes; the negative
	// input is the pair partner or the common pin.
	assign mux_pos_out    = {cfg_q[PAIR_HI], cfg_q[PAIR_LO], cfg_q[POL_POS]};
	assign mux_neg_out    = {cfg_q[PAIR_HI], cfg_q[PAIR_LO], ~cfg_q[POL_POS]};
	assign mux_common_out = cfg_q[SE_POS];
	assign unipolar_out   = cfg_q[UNI_POS];
	assign conv_start_out = conv_start_q;
	assign conv_busy_out  = busy_q;
	assign shutdown_out   = shdn_q;

	// ****************************************************************
	// Checks.
	// ****************************************************************

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_frame_open;
		!act_prev_q ##0 act;
	endsequence

	sequence s_first_bit;
		!serial_oe_n_out ##0 (tx_idx_q == 5'h00);
	endsequence

	property p_open;
		s_frame_open |=> s_first_bit;
	endproperty
	a_open: assert property (p_open) else $error("output not enabled at frame start");

	property p_idle;
		!act |=> $stable(rx_cnt_q) && $stable(tx_idx_q);
	endproperty
	a_idle: assert property (p_idle) else $error("serial state moved while deselected");

	property p_capture;
		sclk_rise && rx_cnt_q < CFG_FULL && !frame_start |=>
			rx_cnt_q == $past(rx_cnt_q) + 4'h1 && cfg_sh_q[0] == $past(pins_s[1]);
	endproperty
	a_capture: assert property (p_capture) else $error("config bit not captured");

	property p_full;
		rx_cnt_q == CFG_FULL && !frame_start |=> $stable(cfg_sh_q);
	endproperty
	a_full: assert property (p_full) else $error("input taken after eighth bit");

	property p_shift_only_fall;
		act_prev_q && !sclk_fall |=> $stable(dout_q);
	endproperty
	a_shift_only_fall: assert property (p_shift_only_fall) else $error("output moved off edge");

	property p_start_busy;
		conv_start_q |=> busy_q ##1 busy_q;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("conversion did not start");

	property p_result;
		done_evt && !conv_start_q && cfg_q[UNI_POS] |=> result_q == $past(code_s);
	endproperty
	a_result: assert property (p_result) else $error("unipolar result wrong");

	property p_bipolar;
		done_evt && !conv_start_q && !cfg_q[UNI_POS] |=>
			result_q[11] != $past(code_s[11]) && result_q[10:0] == $past(code_s[10:0]);
	endproperty
	a_bipolar: assert property (p_bipolar) else $error("bipolar coding wrong");

	property p_shdn;
		end_now && !frame_start && cfg_sh_q[1:0] == 2'b01 |=> shdn_q && !conv_start_q;
	endproperty
	a_shdn: assert property (p_shdn) else $error("shutdown not taken");

	property p_mux;
		conv_start_q |->
			mux_pos_out == {$past(cfg_sh_q[PAIR_HI]), $past(cfg_sh_q[PAIR_LO]),
				$past(cfg_sh_q[POL_POS])} &&
			mux_neg_out[2:1] == mux_pos_out[2:1] && mux_neg_out[0] != mux_pos_out[0];
	endproperty
	a_mux: assert property (p_mux) else $error("multiplexer selection wrong");

endmodule

/* verilog/adcp_sync.sv */
// Two-flop synchroniser for levels entering the system clock domain.
// Assumes each bit is an independent level or a toggle.

`timescale 1ns/1ps

module adcp_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule
